// ### common/sysdec_cfg.svh
// Address map, reset values and field positions for the system decoder.
// Assumes a 32-bit byte address from the processor bus.
`ifndef SYSDEC_CFG_SVH
`define SYSDEC_CFG_SVH
// ---------------------------------------------------------------
// Memory regions (index 0 pflash, 1 dflash, 2 ram, 3 rom)
// ---------------------------------------------------------------
`define RST_BASE_PF 32'h0001_0000
`define RST_SIZE_PF 5'h05
`define RST_BASE_ROM 32'h0000_0000
`define RST_SIZE_ROM 5'h06
`define NRM_BASE_PF 32'h0000_0000
`define NRM_BASE_ROM 32'h0001_0000
`define NRM_SIZE_ROM 5'h02
`define BASE_DF 32'h0001_8800
`define SIZE_DF 5'h01
`define BASE_RAM 32'h0001_9000
`define SIZE_RAM 5'h02
`define SIZE_MAX 5'h0E
`define KB_SHIFT 6'h0A
`define ALL_ONES 32'hFFFF_FFFF
// ---------------------------------------------------------------
// Peripheral windows
// ---------------------------------------------------------------
`define LOOP_FIRST 4'h2
`define LOOP_LAST 4'hE
`define PER_TAG 19'h7_FFBF
`define UART0_TAG 24'hFFF7EC
`define UART1_TAG 24'hFFF7ED
// ---------------------------------------------------------------
// System registers
// ---------------------------------------------------------------
`define DEC_TAG 24'hFFFFFE
`define DEC_BOOT 8'h20
`define CIM_PEND 32'hFFFF_FF20
`define CIM_CLR 32'hFFFF_FF24
`define CIM_MASK 32'hFFFF_FF28
`define CIM_FSEL 32'hFFFF_FF2C
`define CIM_FVEC 32'hFFFF_FF30
`define CIM_IVEC 32'hFFFF_FF34
`define SYS_CTRL 32'hFFFF_FFD0
`define SYS_ALLOW 32'hFFFF_FFD4
`define SYS_STAT 32'hFFFF_FFD8
`define ALLOW_RST 8'h7F
`define CTRL_FAULT 0
`define CTRL_RESET 1
`define CLS_LOOP 4
`define CLS_UART 5
`define CLS_PER 6
`define CLS_SYS 7
`endif

// ### common/sysdec_pkg.sv
// Types for the system decoder, boot sequencer and interrupt unit.
// Assumes nothing beyond a SystemVerilog compiler.
package sysdec_pkg;
    typedef enum logic [2:0] {
        BOOT_INIT = 3'b000,
        BOOT_SHORT = 3'b001,
        BOOT_FULL = 3'b010,
        BOOT_RUN = 3'b011,
        BOOT_MONITOR = 3'b100
    } boot_state_t;
    typedef logic [5:0] vector_t;
endpackage

// ### rtl/system_decode_boot_interrupts.sv
// System module: address decode, protection, boot sequencing, interrupts.
// Assumes the processor bus and all requests share clk_sys_i.
`timescale 1ns/1ps
`include "sysdec_cfg.svh"
module system_decode_boot_interrupts import sysdec_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic priv_i,
    output logic [31:0] rdata_o,
    output logic wait_o,
    input wire logic periph_ready_i,
    output logic [3:0] mem_sel_o,
    output logic [12:0] loop_sel_o,
    output logic [1:0] uart_sel_o,
    output logic [7:0] periph_sel_o,
    output logic fault_o,
    output logic reset_req_o,
    input wire logic chk_done_i,
    input wire logic chk_ok_i,
    output logic chk_start_o,
    output logic chk_full_o,
    output logic boot_run_o,
    output logic boot_monitor_o,
    input wire logic [31:0] irq_req_i,
    output logic fiq_o,
    output logic irq_o
);
    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    logic [31:0] base_reg [4];
    logic [4:0] size_reg [4];
    logic [3:0] mem_hit;
    logic [3:0] mem_one;
    logic [12:0] loop_hit;
    logic [1:0] uart_hit;
    logic per_hit, dec_hit, cim_hit, sys_hit, acc, any_hit, viol;
    logic [7:0] allow_reg;
    logic [1:0] ctrl_reg;
    logic viol_reg;
    logic per_busy_reg;
    logic [31:0] pend_reg, mask_reg, fsel_reg;
    vector_t fvec_next, ivec_next, fvec_reg, ivec_reg;
    boot_state_t boot_reg;

    assign acc = wr_i | rd_i;

    function automatic logic [31:0] size_mask(input logic [4:0] c);
        size_mask = `ALL_ONES << (`KB_SHIFT + {1'b0, c});
    endfunction

    generate
        for (genvar g = 0; g < 4; g++) begin : g_mem
            assign mem_hit[g] =
                ((addr_i ^ base_reg[g]) & size_mask(size_reg[g])) == 32'h0;
        end
        for (genvar g = 0; g < 13; g++) begin : g_loop
            assign loop_hit[g] = addr_i[31:20] == 12'h000 &&
                addr_i[15:8] == 8'h00 &&
                addr_i[19:16] == `LOOP_FIRST + 4'(g);
        end
    endgenerate

    // RAM wins any overlap, then data flash, so scratch data stays reachable
    always_comb begin
        mem_one = 4'h0;
        if (mem_hit[2]) begin
            mem_one[2] = 1'b1;
        end else if (mem_hit[1]) begin
            mem_one[1] = 1'b1;
        end else if (mem_hit[0]) begin
            mem_one[0] = 1'b1;
        end else if (mem_hit[3]) begin
            mem_one[3] = 1'b1;
        end
    end

    assign uart_hit[0] = addr_i[31:8] == `UART0_TAG;
    assign uart_hit[1] = addr_i[31:8] == `UART1_TAG;
    assign per_hit = addr_i[31:13] == `PER_TAG;
    assign dec_hit = addr_i[31:8] == `DEC_TAG;
    assign cim_hit = addr_i >= `CIM_PEND && addr_i <= `CIM_IVEC + 32'h3;
    assign sys_hit = addr_i >= `SYS_CTRL && addr_i <= `SYS_STAT + 32'h3;
    assign any_hit = |mem_one | |loop_hit | per_hit | dec_hit | cim_hit |
        sys_hit;

    // User mode is checked per module class
    always_comb begin
        viol = acc && !any_hit;
        if (acc && !priv_i) begin
            if ((|(mem_one & ~allow_reg[3:0])) ||
                (|loop_hit && !allow_reg[`CLS_LOOP]) ||
                (|uart_hit && !allow_reg[`CLS_UART]) ||
                (per_hit && !allow_reg[`CLS_PER]) ||
                ((dec_hit | cim_hit | sys_hit) && !allow_reg[`CLS_SYS])) begin
                viol = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Selects and wait
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mem_sel_o <= 4'h0;
            loop_sel_o <= 13'h0;
            uart_sel_o <= 2'h0;
            periph_sel_o <= 8'h0;
        end else begin
            mem_sel_o <= acc ? mem_one : 4'h0;
            loop_sel_o <= acc ? loop_hit : 13'h0;
            uart_sel_o <= acc ? uart_hit : 2'h0;
            periph_sel_o <= (acc && per_hit) ?
                8'h01 << addr_i[12:10] : 8'h00;
        end
    end

    // Peripheral stays busy until it reports ready
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            per_busy_reg <= 1'b0;
            wait_o <= 1'b0;
        end else begin
            per_busy_reg <= (acc && per_hit) ||
                (per_busy_reg && !periph_ready_i);
            wait_o <= (acc && dec_hit) || (acc && per_hit) ||
                (per_busy_reg && !periph_ready_i);
        end
    end

    // ---------------------------------------------------------------
    // Decoder registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            base_reg[0] <= `RST_BASE_PF;
            size_reg[0] <= `RST_SIZE_PF;
            base_reg[1] <= `BASE_DF;
            size_reg[1] <= `SIZE_DF;
            base_reg[2] <= `BASE_RAM;
            size_reg[2] <= `SIZE_RAM;
            base_reg[3] <= `RST_BASE_ROM;
            size_reg[3] <= `RST_SIZE_ROM;
        end else if (boot_reg == BOOT_RUN && boot_run_o == 1'b0) begin
            base_reg[0] <= `NRM_BASE_PF;
            base_reg[3] <= `NRM_BASE_ROM;
            size_reg[3] <= `NRM_SIZE_ROM;
        end else if (wr_i && dec_hit && priv_i &&
                     addr_i[7:5] == 3'h0) begin
            if (addr_i[2]) begin
                size_reg[addr_i[4:3]] <= (wdata_i[4:0] > `SIZE_MAX) ?
                    `SIZE_MAX : wdata_i[4:0];
            end else begin
                base_reg[addr_i[4:3]] <= {wdata_i[31:10], 10'h000};
            end
        end
    end

    // ---------------------------------------------------------------
    // Protection
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            allow_reg <= `ALLOW_RST;
            ctrl_reg <= 2'h0;
        end else if (wr_i && priv_i) begin
            if (addr_i == `SYS_CTRL) begin
                ctrl_reg <= wdata_i[1:0];
            end else if (addr_i == `SYS_ALLOW) begin
                allow_reg <= wdata_i[7:0];
            end
        end
    end

    // A new violation wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            viol_reg <= 1'b0;
            fault_o <= 1'b0;
            reset_req_o <= 1'b0;
        end else begin
            if (viol) begin
                viol_reg <= 1'b1;
            end else if (wr_i && priv_i && addr_i == `SYS_STAT &&
                         wdata_i[0]) begin
                viol_reg <= 1'b0;
            end
            fault_o <= viol && ctrl_reg[`CTRL_FAULT];
            reset_req_o <= viol && ctrl_reg[`CTRL_RESET];
        end
    end

    // ---------------------------------------------------------------
    // Boot sequencer
    // ---------------------------------------------------------------
    // Remap happens on the jump so the flash sits at zero for the vector
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            boot_reg <= BOOT_INIT;
            chk_start_o <= 1'b0;
            chk_full_o <= 1'b0;
            boot_run_o <= 1'b0;
            boot_monitor_o <= 1'b0;
        end else begin
            chk_start_o <= 1'b0;
            case (boot_reg)
                BOOT_INIT: begin
                    boot_reg <= BOOT_SHORT;
                    chk_start_o <= 1'b1;
                end
                BOOT_SHORT: begin
                    if (chk_done_i && chk_ok_i) begin
                        boot_reg <= BOOT_RUN;
                    end else if (chk_done_i) begin
                        boot_reg <= BOOT_FULL;
                        chk_start_o <= 1'b1;
                        chk_full_o <= 1'b1;
                    end
                end
                BOOT_FULL: begin
                    if (chk_done_i && chk_ok_i) begin
                        boot_reg <= BOOT_RUN;
                    end else if (chk_done_i) begin
                        boot_reg <= BOOT_MONITOR;
                    end
                end
                BOOT_RUN: begin
                    boot_run_o <= 1'b1;
                end
                BOOT_MONITOR: begin
                    boot_monitor_o <= 1'b1;
                end
                default: begin
                    boot_reg <= BOOT_INIT;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Interrupt unit
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mask_reg <= 32'h0;
            fsel_reg <= 32'h0;
        end else if (wr_i && priv_i && addr_i == `CIM_MASK) begin
            mask_reg <= wdata_i;
        end else if (wr_i && priv_i && addr_i == `CIM_FSEL) begin
            fsel_reg <= wdata_i;
        end
    end

    generate
        for (genvar g = 0; g < 32; g++) begin : g_pend
            // Request in the clearing cycle stays pending
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    pend_reg[g] <= 1'b0;
                end else if (irq_req_i[g]) begin
                    pend_reg[g] <= 1'b1;
                end else if (wr_i && addr_i == `CIM_CLR && wdata_i[g]) begin
                    pend_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Later channels overwrite earlier ones, so 31 wins
    always_comb begin
        fvec_next = 6'h00;
        ivec_next = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (pend_reg[i] && mask_reg[i] && fsel_reg[i]) begin
                fvec_next = {1'b1, 5'(i)};
            end
            if (pend_reg[i] && mask_reg[i] && !fsel_reg[i]) begin
                ivec_next = {1'b1, 5'(i)};
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fvec_reg <= 6'h00;
            ivec_reg <= 6'h00;
            fiq_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            fvec_reg <= fvec_next;
            ivec_reg <= ivec_next;
            fiq_o <= fvec_next[5];
            irq_o <= ivec_next[5];
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    // Memory and peripheral windows answer from their own blocks
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0;
        end else if (!rd_i) begin
            rdata_o <= 32'h0;
        end else if (dec_hit && addr_i[7:5] == 3'h0 && addr_i[2]) begin
            rdata_o <= {27'h0, size_reg[addr_i[4:3]]};
        end else if (dec_hit && addr_i[7:5] == 3'h0) begin
            rdata_o <= base_reg[addr_i[4:3]];
        end else if (dec_hit && addr_i[7:0] == `DEC_BOOT) begin
            rdata_o <= {29'h0, boot_reg};
        end else if (addr_i == `CIM_PEND || addr_i == `CIM_CLR) begin
            rdata_o <= pend_reg;
        end else if (addr_i == `CIM_MASK) begin
            rdata_o <= mask_reg;
        end else if (addr_i == `CIM_FSEL) begin
            rdata_o <= fsel_reg;
        end else if (addr_i == `CIM_FVEC) begin
            rdata_o <= {26'h0, fvec_reg};
        end else if (addr_i == `CIM_IVEC) begin
            rdata_o <= {26'h0, ivec_reg};
        end else if (addr_i == `SYS_CTRL) begin
            rdata_o <= {30'h0, ctrl_reg};
        end else if (addr_i == `SYS_ALLOW) begin
            rdata_o <= {24'h0, allow_reg};
        end else if (addr_i == `SYS_STAT) begin
            rdata_o <= {31'h0, viol_reg};
        end else begin
            rdata_o <= 32'h0;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sequence s_short_fail;
        boot_reg == BOOT_SHORT && chk_done_i && !chk_ok_i;
    endsequence
    sequence s_full_fail;
        boot_reg == BOOT_FULL && chk_done_i && !chk_ok_i;
    endsequence

    a_short_jump: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        boot_reg == BOOT_SHORT && chk_done_i && chk_ok_i
        |-> ##2 boot_run_o && base_reg[0] == `NRM_BASE_PF)
        else $error("short checksum pass did not remap and run");
    a_full_check: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        s_short_fail |=> chk_start_o && chk_full_o && boot_reg == BOOT_FULL)
        else $error("full checksum not started");
    a_boot_monitor: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        s_full_fail |-> ##2 boot_monitor_o && !boot_run_o)
        else $error("monitor not entered");
    a_dec_wait: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        acc && dec_hit |=> wait_o)
        else $error("no wait state on decoder access");
    a_dec_user: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        wr_i && dec_hit && !priv_i
        |=> $stable(base_reg[1]) && $stable(size_reg[2]))
        else $error("user write changed decoder");
    a_loop_win: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        rd_i && addr_i[31:8] == 24'h000E00 |=> loop_sel_o == 13'h1000)
        else $error("last loop window not selected");
    a_uart_win: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        acc && addr_i[31:8] == 24'hFFF7ED |=> uart_sel_o == 2'h2 &&
        periph_sel_o == 8'h08)
        else $error("second serial window wrong");
    a_illegal_fault: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        acc && !any_hit && ctrl_reg[`CTRL_FAULT] |=> fault_o ##1 viol_reg)
        else $error("illegal access gave no fault");
    a_pend_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !(wr_i && addr_i == `CIM_CLR) |=>
        (pend_reg & $past(pend_reg)) == $past(pend_reg))
        else $error("pending lost without clear");
    a_mask_quiet: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        mask_reg == 32'h0 ##1 mask_reg == 32'h0 |=> !fiq_o && !irq_o)
        else $error("masked channel raised interrupt");
    a_top_vector: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        pend_reg[31] && mask_reg[31] && !fsel_reg[31] |=> ivec_reg == 6'h3F)
        else $error("channel 31 not top vector");
endmodule

// ### testbench/boot_check_model.sv
// Far-side model: checksum engine and slow peripheral for the system block.
// Assumes one clock shared with the block and a synchronous reset.
`timescale 1ns/1ps
module boot_check_model #(
    parameter int DLY = 20
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [1:0] ok_pat_i,
    input wire logic [3:0] stall_i,
    input wire logic start_i,
    input wire logic full_i,
    input wire logic [7:0] sel_i,
    output logic done_o,
    output logic ok_o,
    output logic ready_o
);
    // ---------------------------------------------------------------
    // Checksum engine
    // ---------------------------------------------------------------
    logic [7:0] cnt_reg;
    logic busy_reg;
    logic [3:0] hold_reg;
    always_ff @(posedge clk_sys_i) begin
        done_o <= 1'b0;
        if (srst_i) begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
            ok_o <= 1'b0;
        end else if (start_i) begin
            busy_reg <= 1'b1;
            cnt_reg <= 8'(DLY);
            ok_o <= ~ok_o;
        end else if (busy_reg && cnt_reg == 8'h01) begin
            // Verdict per pass: bit 0 short check, bit 1 full check
            busy_reg <= 1'b0;
            done_o <= 1'b1;
            ok_o <= full_i ? ok_pat_i[1] : ok_pat_i[0];
        end else begin
            // Verdict line toggles outside the done pulse, never trusted
            if (busy_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
            ok_o <= ~ok_o;
        end
    end
    // ---------------------------------------------------------------
    // Slow peripheral
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            hold_reg <= 4'h0;
        end else if (|sel_i) begin
            hold_reg <= stall_i;
        end else if (hold_reg != 4'h0) begin
            hold_reg <= hold_reg - 4'h1;
        end
    end
    assign ready_o = (hold_reg == 4'h0) && !((|sel_i) && stall_i != 4'h0);
endmodule

// ### testbench/tb.sv
// Self-checking bench for the system decode, boot and interrupt block.
// Assumes the block's one-cycle strobe bus and the far-side model.
`timescale 1ns/1ps
module tb;
    logic clk_sys_i, srst_i, wr_i, rd_i, priv_i, wait_o, fault_o;
    logic [31:0] addr_i, wdata_i, rdata_o, irq_req_i, rd_q;
    logic [3:0] mem_sel_o, mem_q, stall;
    logic [12:0] loop_sel_o, loop_q;
    logic [1:0] uart_sel_o, uart_q, ok_pat;
    logic [7:0] periph_sel_o, per_q;
    logic reset_req_o, chk_done_i, chk_ok_i, chk_start_o, chk_full_o;
    logic boot_run_o, boot_monitor_o, fiq_o, irq_o, periph_ready_i, wait_q;
    int fail_count, total_checks, flt_n, rst_n, n;
    logic [31:0] ma[6] = '{32'h7FFF, 32'h1_0000, 32'h1_8800,
                           32'h1_8FFF, 32'h1_9000, 32'h1_9FFF};
    logic [3:0] me[6] = '{4'h1, 4'h8, 4'h2, 4'h2, 4'h4, 4'h4};
    system_decode_boot_interrupts u_system_decode_boot_interrupts (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .priv_i(priv_i),
        .rdata_o(rdata_o), .wait_o(wait_o), .periph_ready_i(periph_ready_i),
        .mem_sel_o(mem_sel_o), .loop_sel_o(loop_sel_o),
        .uart_sel_o(uart_sel_o), .periph_sel_o(periph_sel_o),
        .fault_o(fault_o), .reset_req_o(reset_req_o),
        .chk_done_i(chk_done_i), .chk_ok_i(chk_ok_i),
        .chk_start_o(chk_start_o), .chk_full_o(chk_full_o),
        .boot_run_o(boot_run_o), .boot_monitor_o(boot_monitor_o),
        .irq_req_i(irq_req_i), .fiq_o(fiq_o), .irq_o(irq_o));
    boot_check_model u_boot_check_model (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ok_pat_i(ok_pat),
        .stall_i(stall), .start_i(chk_start_o), .full_i(chk_full_o),
        .sel_i(periph_sel_o), .done_o(chk_done_i), .ok_o(chk_ok_i),
        .ready_o(periph_ready_i));
    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (fault_o === 1'b1) flt_n++;
        if (reset_req_o === 1'b1) rst_n++;
    end
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            $display("MISMATCH %s exp %h got %h", nm, e, s);
            fail_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, input logic p);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        priv_i <= p;
        wr_i <= w;
        rd_i <= !w;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1;
        rd_q = rdata_o;
        mem_q = mem_sel_o;
        loop_q = loop_sel_o;
        uart_q = uart_sel_o;
        per_q = periph_sel_o;
        wait_q = wait_o;
    endtask
    task automatic settle(input logic [31:0] req);
        @(posedge clk_sys_i);
        irq_req_i <= req;
        @(posedge clk_sys_i);
        irq_req_i <= 32'h0000_0000;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic test_done();
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        srst_i = 1'b1;
        {addr_i, wdata_i, irq_req_i, wr_i, rd_i} = '0;
        priv_i = 1'b1;
        stall = 4'h3;
        // Patterns: both fail, short passes, short fails then full passes
        for (int k = 0; k < 3; k++) begin
            ok_pat = 2'(k);
            srst_i <= 1'b1;
            repeat (10) @(posedge clk_sys_i);
            srst_i <= 1'b0;
            bus(1'b0, 32'h0, 32'h0, 1'b1);
            chk("rom_at_zero", 32'h8, mem_q);
            n = 0;
            while (!(boot_run_o || boot_monitor_o) && n < 300) begin
                @(posedge clk_sys_i);
                n++;
            end
            if (n == 300) begin
                fail_count++;
                test_done();
            end
            #1;
            chk("boot_run", k != 0, boot_run_o);
            chk("boot_monitor", k == 0, boot_monitor_o);
            chk("chk_full", k != 1, chk_full_o);
            bus(1'b0, 32'h0, 32'h0, 1'b1);
            chk("map_zero", (k != 0) ? 32'h1 : 32'h8, mem_q);
        end
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, ma[i], 32'h0, 1'b1);
            chk("mem_sel", me[i], mem_q);
        end
        for (int k = 0; k < 13; k++) begin
            bus(1'b0, (32'(k + 2) << 16) + 32'(k * 19), 32'h0, 1'b1);
            chk("loop_sel", 32'(13'h1 << k), loop_q);
        end
        bus(1'b0, 32'hFFF7_EC00, 32'h0, 1'b1);
        chk("uart0", 32'h1, uart_q);
        bus(1'b0, 32'hFFF7_EDFF, 32'h0, 1'b1);
        chk("uart1", 32'h2, uart_q);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 32'hFFF7_E000 + 32'(i * 32'h400), 32'h0, 1'b1);
            chk("periph_sel", 32'(8'h1 << i), per_q);
            n = 0;
            while (wait_o !== 1'b0 && n < 12) begin
                @(posedge clk_sys_i);
                #1;
                n++;
            end
            chk("periph_stretch", 32'h1, wait_q && n >= 2 && n < 12);
            if (n == 12) test_done();
        end
        bus(1'b1, 32'hFFFF_FE14, 32'h0, 1'b1);
        chk("dec_wait", 32'h1, wait_q);
        bus(1'b1, 32'hFFFF_FE14, 32'h5, 1'b0);
        bus(1'b0, 32'hFFFF_FE14, 32'h0, 1'b1);
        chk("dec_user_wr", 32'h0, rd_q);
        bus(1'b0, 32'h1_9400, 32'h0, 1'b1);
        chk("ram_1k_out", 32'h0, mem_q);
        bus(1'b0, 32'h1_93FF, 32'h0, 1'b1);
        chk("ram_1k_in", 32'h4, mem_q);
        bus(1'b1, 32'hFFFF_FE14, 32'h2, 1'b1);
        // Interrupts: channels 3, 5, 9, 20 open, 9 on the fast level
        bus(1'b1, 32'hFFFF_FF24, 32'hFFFF_FFFF, 1'b1);
        bus(1'b1, 32'hFFFF_FF28, 32'h0010_0228, 1'b1);
        bus(1'b1, 32'hFFFF_FF2C, 32'h0000_0200, 1'b1);
        settle(32'h0000_0080);
        chk("masked_irq", 32'h0, {fiq_o, irq_o});
        settle(32'h0000_0020);
        chk("irq_level", 32'h1, {fiq_o, irq_o});
        bus(1'b0, 32'hFFFF_FF34, 32'h0, 1'b1);
        chk("ivec_5", 32'h25, rd_q);
        settle(32'h0010_0008);
        bus(1'b0, 32'hFFFF_FF34, 32'h0, 1'b1);
        chk("ivec_20", 32'h34, rd_q);
        settle(32'h0000_0200);
        chk("fiq_level", 32'h3, {fiq_o, irq_o});
        bus(1'b0, 32'hFFFF_FF30, 32'h0, 1'b1);
        chk("fvec_9", 32'h29, rd_q);
        bus(1'b1, 32'hFFFF_FF24, 32'h0010_0000, 1'b0);
        bus(1'b0, 32'hFFFF_FF34, 32'h0, 1'b1);
        chk("ivec_after_clr", 32'h25, rd_q);
        bus(1'b1, 32'hFFFF_FF28, 32'h8010_0228, 1'b1);
        settle(32'h8000_0000);
        bus(1'b0, 32'hFFFF_FF34, 32'h0, 1'b1);
        chk("ivec_31", 32'h3F, rd_q);
        bus(1'b1, 32'hFFFF_FF24, 32'hFFFF_FFFF, 1'b1);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("irq_cleared", 32'h0, {fiq_o, irq_o});
        // Protection: fault, per-class permission, then reset request
        bus(1'b1, 32'hFFFF_FFD0, 32'h1, 1'b1);
        flt_n = 0;
        rst_n = 0;
        bus(1'b0, 32'h0010_0000, 32'h0, 1'b1);
        repeat (3) @(posedge clk_sys_i);
        chk("fault_unmapped", 32'h1, 32'(flt_n));
        bus(1'b0, 32'hFFFF_FFD8, 32'h0, 1'b1);
        chk("viol_status", 32'h1, rd_q & 32'h1);
        bus(1'b1, 32'hFFFF_FFD4, 32'h6F, 1'b1);
        bus(1'b0, 32'h0002_0000, 32'h0, 1'b0);
        repeat (3) @(posedge clk_sys_i);
        chk("fault_user", 32'h2, 32'(flt_n));
        bus(1'b1, 32'hFFFF_FFD4, 32'h7F, 1'b1);
        bus(1'b0, 32'h0002_0000, 32'h0, 1'b0);
        repeat (3) @(posedge clk_sys_i);
        chk("user_allowed", 32'h2, 32'(flt_n));
        bus(1'b1, 32'hFFFF_FFD0, 32'h2, 1'b1);
        bus(1'b0, 32'h0010_0000, 32'h0, 1'b1);
        repeat (3) @(posedge clk_sys_i);
        chk("reset_req", 32'h0001_0002, {16'(rst_n), 16'(flt_n)});
        test_done();
    end
endmodule
